/* lb_activity_monitor.sv */
// leaky-bucket input activity monitor with its configuration registers
module lb_activity_monitor
    import lb_monitor_pkg::*;
#(
    parameter int CYCLE_CLKS_P = CYCLE_CLKS
) (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       failSeen,    // pulse from detector: failed or erratic
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regWrData,
    input  wire logic       regRdEn,
    output logic      [7:0] regRdData,
    output logic      [7:0] bucketLevel,
    output logic            inactAlarm
);

    //--------------------------------------------------------------------------
    // configuration registers
    //--------------------------------------------------------------------------
    logic [7:0] upperLevel_r;    // alarm raise level
    logic [7:0] alarm_clear_level_cfg3_r;
    logic [7:0] bucket_capacity_cfg3_r;
    logic [1:0] decayCode_r;     // 0..3 selects 1, 2, 4, 8 clean cycles

    //--------------------------------------------------------------------------
    // bucket state
    //--------------------------------------------------------------------------
    logic [7:0] acc_r;           // bucket count
    logic [7:0] acc_nxt;
    logic [2:0] cleanCnt_r;      // clean cycles since last bad cycle or completed run
    logic [2:0] cleanCnt_nxt;
    logic       badSeen_r;       // bad event seen in the running cycle
    logic       alarm_r;
    logic       alarm_nxt;
    logic [7:0] rdData_r;
    logic       cycleTick;       // end of monitoring cycle

    //--------------------------------------------------------------------------
    // cycle divider
    //--------------------------------------------------------------------------
    lb_cycle_timer #(
        .CYCLE_CLKS_P (CYCLE_CLKS_P)
    ) u_timer (
        .mclk      (mclk),
        .srst      (srst),
        .cycleTick (cycleTick)
    );

    //--------------------------------------------------------------------------
    // write decode
    //--------------------------------------------------------------------------
    wire wrUpper = regWrEn && (regAddr == OFS_UPPER);
    wire wrLower = regWrEn && (regAddr == OFS_LOWER);
    wire wrSize  = regWrEn && (regAddr == OFS_SIZE);
    wire wrDecay = regWrEn && (regAddr == OFS_DECAY);

    // RQ6 lower threshold register
    // RQ7 bucket size register
    always_ff @(posedge mclk) begin
        if (srst) begin
            upperLevel_r             <= RST_UPPER;
            alarm_clear_level_cfg3_r <= RST_LOWER;
            bucket_capacity_cfg3_r   <= RST_SIZE;
            decayCode_r              <= RST_DECAY;
        end else begin
            if (wrUpper) begin
                upperLevel_r <= regWrData;
            end
            if (wrLower) begin
                alarm_clear_level_cfg3_r <= regWrData;
            end
            if (wrSize) begin
                bucket_capacity_cfg3_r <= regWrData;
            end
            // unused upper bits of the decay register are dropped
            if (wrDecay) begin
                decayCode_r <= regWrData[DECAY_LSB +: 2];
            end
        end
    end

    //--------------------------------------------------------------------------
    // read decode: registered, unmapped addresses read zero
    //--------------------------------------------------------------------------
    logic [7:0] rdMux;
    always_comb begin
        if (regAddr == OFS_UPPER) begin
            rdMux = upperLevel_r;
        end else if (regAddr == OFS_LOWER) begin
            rdMux = alarm_clear_level_cfg3_r;
        end else if (regAddr == OFS_SIZE) begin
            rdMux = bucket_capacity_cfg3_r;
        end else if (regAddr == OFS_DECAY) begin
            rdMux = {6'h00, decayCode_r};
        end else if (regAddr == OFS_LEVEL) begin
            rdMux = acc_r;
        end else if (regAddr == OFS_STATUS) begin
            rdMux = 8'h00 | (8'(alarm_r) << ALARM_BIT);
        end else begin
            rdMux = 8'h00;
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdData_r <= 8'h00;
        end else if (regRdEn) begin
            rdData_r <= rdMux;
        end
    end

    //--------------------------------------------------------------------------
    // bucket arithmetic
    //--------------------------------------------------------------------------
    // an event landing on the tick itself still counts for the ending cycle
    wire       badNow  = badSeen_r | failSeen;
    wire [3:0] runLen  = 4'h1 << decayCode_r;
    // at or past the run length, so a shortened decay code leaks at once
    wire       runDone = ({1'b0, cleanCnt_r} + 4'h1) >= runLen;
    wire       atCap   = acc_r >= bucket_capacity_cfg3_r;

    always_comb begin
        acc_nxt      = acc_r;
        cleanCnt_nxt = cleanCnt_r;
        if (badNow) begin
            // RQ2 fill by one
            // RQ5 clamp at capacity
            acc_nxt      = atCap ? bucket_capacity_cfg3_r : acc_r + 8'h01;
            cleanCnt_nxt = 3'h0;
        end else if (runDone) begin
            // RQ3 leak after run
            // RQ9 never below zero
            acc_nxt      = (acc_r == 8'h00) ? 8'h00 : acc_r - 8'h01;
            cleanCnt_nxt = 3'h0;
        end else begin
            cleanCnt_nxt = cleanCnt_r + 3'h1;
        end
    end

    //--------------------------------------------------------------------------
    // alarm hysteresis
    //--------------------------------------------------------------------------
    always_comb begin
        alarm_nxt = alarm_r;
        // RQ8 raise at upper level
        if (acc_nxt >= upperLevel_r) begin
            alarm_nxt = 1'b1;
        // RQ4 clear at lower level
        end else if (acc_nxt <= alarm_clear_level_cfg3_r) begin
            alarm_nxt = 1'b0;
        end
        // RQ9 between thresholds the alarm holds
    end

    //--------------------------------------------------------------------------
    // bucket state update
    //--------------------------------------------------------------------------
    // RQ1 update once per cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            acc_r      <= 8'h00;
            cleanCnt_r <= 3'h0;
            alarm_r    <= 1'b0;
        end else if (cycleTick) begin
            acc_r      <= acc_nxt;
            cleanCnt_r <= cleanCnt_nxt;
            alarm_r    <= alarm_nxt;
        end
    end

    // sticky bad flag for the running cycle; a fail on the tick clock
    // is already counted for the ending cycle through badNow
    always_ff @(posedge mclk) begin
        if (srst) begin
            badSeen_r <= 1'b0;
        end else if (cycleTick) begin
            badSeen_r <= 1'b0;
        end else if (failSeen) begin
            badSeen_r <= 1'b1;
        end
    end

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    assign regRdData   = rdData_r;
    assign bucketLevel = acc_r;
    assign inactAlarm  = alarm_r;

    //--------------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_hold_between_ticks;
        !cycleTick && !srst |=> $stable(acc_r) && $stable(alarm_r);
    endproperty
    a_hold_between_ticks: assert property (p_hold_between_ticks) // RQ1
        else $error("bucket changed outside a cycle end");

    property p_fill;
        cycleTick && badNow && !atCap |=> acc_r == $past(acc_r) + 8'h01;
    endproperty
    a_fill: assert property (p_fill) // RQ2
        else $error("bad cycle did not add one");

    property p_leak;
        cycleTick && !badNow && runDone && acc_r != 8'h00
            |=> acc_r == $past(acc_r) - 8'h01;
    endproperty
    a_leak: assert property (p_leak) // RQ3
        else $error("clean run did not subtract one");

    property p_no_early_leak;
        cycleTick && !badNow && !runDone |=> acc_r == $past(acc_r);
    endproperty
    a_no_early_leak: assert property (p_no_early_leak) // RQ3
        else $error("bucket leaked before run complete");

    property p_cap;
        cycleTick && badNow |=> acc_r <= $past(bucket_capacity_cfg3_r);
    endproperty
    a_cap: assert property (p_cap) // RQ5
        else $error("bucket exceeded capacity");

    property p_floor;
        cycleTick && !badNow && acc_r == 8'h00 |=> acc_r == 8'h00;
    endproperty
    a_floor: assert property (p_floor) // RQ9
        else $error("bucket wrapped below zero");

    property p_raise;
        cycleTick && acc_nxt >= upperLevel_r |=> alarm_r;
    endproperty
    a_raise: assert property (p_raise) // RQ8
        else $error("alarm not raised at upper level");

    property p_clear;
        cycleTick && acc_nxt < upperLevel_r && acc_nxt <= alarm_clear_level_cfg3_r
            |=> !alarm_r;
    endproperty
    a_clear: assert property (p_clear) // RQ4
        else $error("alarm not cleared at lower level");

    property p_hyst;
        cycleTick && acc_nxt < upperLevel_r && acc_nxt > alarm_clear_level_cfg3_r
            |=> alarm_r == $past(alarm_r);
    endproperty
    a_hyst: assert property (p_hyst) // RQ9
        else $error("alarm moved between thresholds");

    property p_reset_vals;
        @(posedge mclk) disable iff (1'b0)
            srst |=> alarm_clear_level_cfg3_r == RST_LOWER
            && bucket_capacity_cfg3_r == RST_SIZE;
    endproperty
    a_reset_vals: assert property (p_reset_vals) // RQ7
        else $error("threshold or size reset value wrong");

endmodule

/* lb_activity_monitor_test.sv */
// self-checking bench for the leaky-bucket activity monitor
module lb_activity_monitor_test
    import lb_monitor_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    //--------------------------------------------------------------------------
    // signals and model state
    //--------------------------------------------------------------------------
    localparam int CYC = 8;              // short monitoring cycle for simulation
    logic       mclk, srst, failSeen;    // clock, reset, detector pulse
    logic       regWrEn, regRdEn;        // register strobes
    logic [7:0] regAddr, regWrData;      // register request
    logic [7:0] regRdData, bucketLevel;  // design answers
    logic       inactAlarm;              // design alarm
    int         badCount, testsRun;      // verdict counters
    int         mcnt, lvl, clean, mode;  // model phase, count, clean run, traffic kind
    logic       alm, bad, badT, pend;    // model alarm and cycle flags
    logic       badPlan;                 // current cycle is meant to be bad
    logic [7:0] upper, lower, size;      // model thresholds
    logic [1:0] decay;                   // model clean-run code
    logic [16:0] lfsr, rnd;              // stimulus and config generators

    lb_activity_monitor #(.CYCLE_CLKS_P(CYC)) dut (
        .mclk(mclk), .srst(srst), .failSeen(failSeen), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .bucketLevel(bucketLevel), .inactAlarm(inactAlarm));

    //--------------------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------------------
    function automatic logic [16:0] lfsrNext(input logic [16:0] x);
        return {x[15:0], x[16] ^ x[13]};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            badCount++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic testDone;
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [7:0] expOf(input logic [7:0] a);
        case (a)
            OFS_UPPER:  return upper;
            OFS_LOWER:  return lower;
            OFS_SIZE:   return size;
            OFS_DECAY:  return {6'h00, decay};   // spare bits read zero
            OFS_LEVEL:  return lvl[7:0];
            OFS_STATUS: return {7'h00, alm};
            default:    return 8'h00;             // unmapped reads zero
        endcase
    endfunction

    // register accesses start just after an update edge, clear of tick edges
    task automatic sync;
        do begin @(posedge mclk); #2; end while (mcnt != 1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sync();
        regAddr = a; regWrData = d; regWrEn = 1'b1;
        @(posedge mclk);
        case (a)
            OFS_UPPER: upper = d;
            OFS_LOWER: lower = d;
            OFS_SIZE:  size = d;
            OFS_DECAY: decay = d[1:0];
            default:   ;                            // read-only or unmapped
        endcase
        #2 regWrEn = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        sync();
        regAddr = a; regRdEn = 1'b1;
        @(posedge mclk);
        e = expOf(a);
        #2 regRdEn = 1'b0;
        check(regRdData, e);
    endtask

    task automatic cycles(input int m, input int n);
        mode = m;
        repeat (n * CYC) @(posedge mclk);
    endtask

    //--------------------------------------------------------------------------
    // clock and behavioural model
    //--------------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (srst) begin
            mcnt = 0; lvl = 0; clean = 0; alm = 0; bad = 0; pend = 0; badT = 0;
            upper = 8'h06; lower = 8'h04; size = 8'h08; decay = 2'h1;
        end else begin
            if (pend) begin
                if (badT) begin
                    clean = 0;
                    lvl = (lvl >= size) ? size : lvl + 1;   // clamp, not wrap
                end else if (++clean >= (1 << decay)) begin
                    clean = 0;
                    if (lvl > 0) lvl--;                      // never below zero
                end
                if (lvl >= upper) alm = 1'b1;                // raise wins a tie
                else if (lvl <= lower) alm = 1'b0;           // else hold: hysteresis
            end
            pend = (mcnt == CYC - 1);
            if (pend) begin badT = bad | failSeen; bad = 1'b0; end
            else bad = bad | failSeen;
            mcnt = pend ? 0 : mcnt + 1;
        end
    end

    // detector pulses sit mid-cycle so their cycle is never in doubt
    always @(posedge mclk) begin
        #2;
        if (mcnt == 1) begin
            lfsr = lfsrNext(lfsr);
            badPlan = (mode == 1) || (mode == 2 && lfsr[0]);
        end
        failSeen = !srst && badPlan && (mcnt == 3 || mcnt == 4);
        if (!srst && mcnt == 3) begin
            check(bucketLevel, lvl[7:0]);
            check({7'h00, inactAlarm}, {7'h00, alm});
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        badCount++;
        testDone();
    end

    //--------------------------------------------------------------------------
    // main sequence
    //--------------------------------------------------------------------------
    initial begin
        srst = 1'b1; failSeen = 1'b0; regWrEn = 1'b0; regRdEn = 1'b0;
        regAddr = 8'h00; regWrData = 8'h00; mode = 0; badPlan = 1'b0;
        badCount = 0; testsRun = 0; lfsr = 17'd94818; rnd = 17'd94818;
        repeat (16) @(posedge mclk);
        #2 srst = 1'b0;
        check(regRdData, 8'h00);
        // reset values, then spare bits, read-only and unmapped places
        for (int a = 8'h5C; a <= 8'h62; a++) rd(a[7:0]);
        wr(OFS_UPPER, 8'h05); wr(OFS_LOWER, 8'h02); wr(OFS_SIZE, 8'h07);
        wr(OFS_DECAY, 8'hFF); wr(OFS_LEVEL, 8'h33); wr(8'h70, 8'h11);
        for (int a = 8'h5C; a <= 8'h62; a++) rd(a[7:0]);
        rd(8'h70);
        // fill past capacity, then drain at every clean-run code
        for (int k = 0; k < 4; k++) begin
            wr(OFS_DECAY, k[7:0]);
            cycles(1, 9);
            rd(OFS_LEVEL); rd(OFS_STATUS);
            cycles(0, 9 << k);
            rd(OFS_LEVEL); rd(OFS_STATUS);
        end
        // second reset in mid-run, while the bucket is filling
        cycles(1, 3);
        #2 srst = 1'b1;
        mode = 0;
        repeat (16) @(posedge mclk);
        #2 srst = 1'b0;
        check(regRdData, 8'h00);
        for (int a = 8'h5C; a <= 8'h61; a++) rd(a[7:0]);
        // random traffic under random limits
        repeat (6) begin
            rnd = lfsrNext(rnd);
            wr(OFS_UPPER, 8'h03 + {5'h00, rnd[2:0]});
            wr(OFS_LOWER, {6'h00, rnd[9:8]});
            wr(OFS_SIZE, 8'h04 + {5'h00, rnd[12:10]});
            wr(OFS_DECAY, {6'h00, rnd[15:14]});
            cycles(2, 30);
            rd(OFS_LEVEL); rd(OFS_STATUS);
        end
        testDone();
    end
endmodule

/* lb_cycle_timer.sv */
// divider that marks the end of each monitoring cycle with a one-cycle pulse
module lb_cycle_timer
    import lb_monitor_pkg::*;
#(
    parameter int CYCLE_CLKS_P = CYCLE_CLKS
) (
    input  wire logic mclk,
    input  wire logic srst,
    output logic      cycleTick
);

    //--------------------------------------------------------------------------
    // cycle counter
    //--------------------------------------------------------------------------
    logic [CYC_W-1:0] cnt_r;     // clocks elapsed in the current cycle
    logic [CYC_W-1:0] cnt_nxt;
    wire              atEnd;     // last clock of the cycle

    assign atEnd   = (cnt_r == CYC_W'(CYCLE_CLKS_P - 1));
    assign cnt_nxt = atEnd ? '0 : cnt_r + CYC_W'(1);

    // free-running count, restarted by reset so cycles align to reset release
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_r     <= '0;
            cycleTick <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            cycleTick <= atEnd;
        end
    end

endmodule

/* lb_monitor_pkg.sv */
// constants and register map for the leaky-bucket activity monitor
//------------------------------------------------------------------------------
// Functional notes
// RQ1: bucket evaluated once per 128 ms cycle
// RQ2: each failed or erratic cycle adds one
// RQ3: clean run of 1/2/4/8 cycles subtracts one
// RQ4: alarm clears at programmed lower threshold
// RQ5: count saturates at programmed bucket size
// RQ6: lower threshold resets to 0x04, read/write
// RQ7: bucket size at 0x5E resets 0x08
// RQ8: alarm raised when count reaches upper threshold
// RQ9: no underflow; alarm held between thresholds
//------------------------------------------------------------------------------
package lb_monitor_pkg;

    //--------------------------------------------------------------------------
    // register offsets
    //--------------------------------------------------------------------------
    localparam logic [7:0] OFS_UPPER   = 8'h5C;  // alarm raise level
    localparam logic [7:0] OFS_LOWER   = 8'h5D;  // alarm clear level
    localparam logic [7:0] OFS_SIZE    = 8'h5E;  // bucket capacity
    localparam logic [7:0] OFS_DECAY   = 8'h5F;  // clean-run length code
    localparam logic [7:0] OFS_LEVEL   = 8'h60;  // live bucket count, read only
    localparam logic [7:0] OFS_STATUS  = 8'h61;  // alarm state, read only

    //--------------------------------------------------------------------------
    // reset values and field layout
    //--------------------------------------------------------------------------
    localparam logic [7:0] RST_UPPER   = 8'h06;
    localparam logic [7:0] RST_LOWER   = 8'h04;
    localparam logic [7:0] RST_SIZE    = 8'h08;
    localparam logic [1:0] RST_DECAY   = 2'h1;
    localparam int         DECAY_LSB   = 0;      // decay code sits in bits [1:0]
    localparam int         ALARM_BIT   = 0;      // alarm flag in status register

    //--------------------------------------------------------------------------
    // timing
    //--------------------------------------------------------------------------
    localparam int CYCLE_MS    = 128;            // monitoring cycle length
    localparam int CLK_KHZ     = 40_000;         // mclk rate
    localparam int CYCLE_CLKS  = CYCLE_MS * CLK_KHZ;
    localparam int CYC_W       = 23;             // holds CYCLE_CLKS - 1

endpackage
